// ### verilog/dwnv_pkg.sv
// Shared constants, command codes and wiper arithmetic of the dual wiper control block.
package dwnv_pkg;

    localparam int         FRAME_BITS     = 16;
    localparam int         CMD_LSB        = 12;
    localparam int         ADDR_LSB       = 8;
    localparam int         DATA_LSB       = 0;
    localparam logic [3:0] CMD_NOP        = 4'h0;
    localparam logic [3:0] CMD_RELOAD     = 4'h1;
    localparam logic [3:0] CMD_SAVE       = 4'h2;
    localparam logic [3:0] CMD_DEC_6DB    = 4'h4;
    localparam logic [3:0] CMD_DEC_STEP   = 4'h6;
    localparam logic [3:0] CMD_RELOAD_ALL = 4'h8;
    localparam logic [3:0] CMD_LOAD       = 4'hb;
    localparam logic [3:0] CMD_INC_6DB    = 4'hc;
    localparam logic [3:0] CMD_INC_STEP   = 4'he;
    localparam logic [7:0] WIPER_MIN      = 8'h00;
    localparam logic [7:0] WIPER_MID      = 8'h80;
    localparam logic [7:0] WIPER_MAX      = 8'hff;
    localparam logic       READY_RESET    = 1'b1;
    localparam int         CLK_HZ         = 10_000_000;
    localparam int         SAVE_TIME_MS   = 25;
    localparam int         SAVE_CYCLES    = (CLK_HZ / 1000) * SAVE_TIME_MS;

    // Step and 6 dB arithmetic; every form stops at the end of the range.
    function automatic logic [7:0] dwnv_step(input logic [7:0] v, input logic [3:0] op);
        logic [7:0] r;
        r = v;
        case (op)
            CMD_INC_STEP: r = (v == WIPER_MAX) ? v : v + 8'h01;
            CMD_DEC_STEP: r = (v == WIPER_MIN) ? v : v - 8'h01;
            CMD_INC_6DB:  r = v[7] ? WIPER_MAX : ((v == WIPER_MIN) ? 8'h01 : {v[6:0], 1'b0});
            CMD_DEC_6DB:  r = {1'b0, v[7:1]};
            default:      r = v;
        endcase
        return r;
    endfunction

    function automatic logic dwnv_is_repeatable(input logic [3:0] op);
        return (op == CMD_INC_STEP) || (op == CMD_DEC_STEP) ||
               (op == CMD_INC_6DB) || (op == CMD_DEC_6DB);
    endfunction

endpackage

// ### verilog/dwnv_links.sv
// Interfaces that join the control core to its serial port and its saved-setting store.
`timescale 1ns/1ps
`default_nettype none
interface dwnv_frame_if;
    logic        frame_ok;
    logic        bare_strobe;
    logic [15:0] word;
    modport port (output frame_ok, output bare_strobe, output word);
    modport ctrl (input frame_ok, input bare_strobe, input word);
endinterface

interface dwnv_nv_if;
    logic       save_req;
    logic       save_ch;
    logic [7:0] save_data;
    logic       busy;
    logic       done;
    logic [7:0] slot0;
    logic [7:0] slot1;
    modport store (input save_req, input save_ch, input save_data,
                   output busy, output done, output slot0, output slot1);
    modport ctrl (output save_req, output save_ch, output save_data,
                  input busy, input done, input slot0, input slot1);
endinterface
`default_nettype wire

// ### verilog/dwnv_serial_port.sv
// Serial frame receiver with pass-through output for chaining several devices.
`timescale 1ns/1ps
`default_nettype none
module dwnv_serial_port (
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    input  wire logic  sclk_i,
    input  wire logic  sdi_i,
    input  wire logic  cs_n_i,
    input  wire logic  lock_i,
    output logic       sdo_oe_o,
    dwnv_frame_if.port fr
);
    logic [2:0]  sclk_reg;
    logic [1:0]  sdi_reg;
    logic [2:0]  cs_reg;
    logic [15:0] shift_reg;
    logic [3:0]  cnt_reg;
    logic        seen_reg;
    logic        sclk_rise;
    logic        cs_rise;

    // Bit 0 of each chain only feeds bit 1; edges are taken from the later stages.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_reg <= 3'h0;
            sdi_reg  <= 2'h0;
            cs_reg   <= 3'h7;
        end else begin
            sclk_reg <= {sclk_reg[1:0], sclk_i};
            sdi_reg  <= {sdi_reg[0], sdi_i};
            cs_reg   <= {cs_reg[1:0], cs_n_i};
        end
    end

    assign sclk_rise = sclk_reg[1] & ~sclk_reg[2];
    assign cs_rise   = cs_reg[1] & ~cs_reg[2];

    // Old contents leave at the top as new bits enter at the bottom.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_reg <= 16'h0000;
            cnt_reg   <= 4'h0;
            seen_reg  <= 1'b0;
        end else if (cs_rise) begin
            cnt_reg  <= 4'h0;
            seen_reg <= 1'b0;
        end else if (sclk_rise && !cs_reg[1] && !lock_i) begin
            shift_reg <= {shift_reg[14:0], sdi_reg[1]};
            cnt_reg   <= cnt_reg + 4'h1;
            seen_reg  <= 1'b1;
        end
    end

    // Only whole multiples of sixteen bits make a frame; other counts are dropped.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fr.frame_ok    <= 1'b0;
            fr.bare_strobe <= 1'b0;
            fr.word        <= 16'h0000;
        end else begin
            fr.frame_ok    <= cs_rise && seen_reg && cnt_reg == 4'h0
                              && !lock_i;
            fr.bare_strobe <= cs_rise && !seen_reg && !lock_i;
            if (cs_rise)
                fr.word <= shift_reg;
        end
    end

    // Open drain: pull low only while selected and the outgoing bit is zero.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            sdo_oe_o <= 1'b0;
        else
            sdo_oe_o <= !cs_reg[1] && !shift_reg[15];
    end
endmodule
`default_nettype wire

// ### verilog/dwnv_nv_store.sv
// Two saved wiper settings with a timed write that keeps the port busy.
`timescale 1ns/1ps
`default_nettype none
module dwnv_nv_store #(
    parameter int SAVE_CYCLES = dwnv_pkg::SAVE_CYCLES
) (
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    dwnv_nv_if.store    nv
);
    logic [31:0] timer_reg;
    logic        ch_reg;
    logic [7:0]  data_reg;

    // Reset here stands for the factory state of the cells.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            nv.slot0 <= dwnv_pkg::WIPER_MID;
            nv.slot1 <= dwnv_pkg::WIPER_MID;
            nv.busy  <= 1'b0;
            nv.done  <= 1'b0;
            timer_reg <= 32'h0;
            ch_reg    <= 1'b0;
            data_reg  <= 8'h00;
        end else begin
            nv.done <= 1'b0;
            if (!nv.busy && nv.save_req) begin
                nv.busy   <= 1'b1;
                ch_reg    <= nv.save_ch;
                data_reg  <= nv.save_data;
                timer_reg <= 32'(SAVE_CYCLES - 1);
            end else if (nv.busy && timer_reg != 32'h0) begin
                timer_reg <= timer_reg - 32'h1;
            end else if (nv.busy) begin
                nv.busy <= 1'b0;
                nv.done <= 1'b1;
                if (ch_reg)
                    nv.slot1 <= data_reg;
                else
                    nv.slot0 <= data_reg;
            end
        end
    end
endmodule
`default_nettype wire

// ### verilog/dwnv_ctrl.sv
// Top of the dual wiper control: command decode, wipers, preset and ready logic.
`timescale 1ns/1ps
`default_nettype none
module dwnv_ctrl #(
    parameter int SAVE_CYCLES = dwnv_pkg::SAVE_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       sclk_i,
    input  wire logic       sdi_i,
    input  wire logic       cs_n_i,
    output logic            sdo_o,
    output logic            sdo_oe_o,
    input  wire logic       reload_strobe_n_i,
    input  wire logic       write_protect_n_i,
    output logic            ready_o,
    output logic            ready_oe_o,
    output logic [7:0]      wiper1_o,
    output logic [7:0]      wiper2_o
);

    // ************************************************************
    // Sub-blocks
    // ************************************************************

    dwnv_frame_if fr ();
    dwnv_nv_if    nv ();

    logic sdo_oe_port;

    dwnv_serial_port u_port (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .sclk_i   (sclk_i),
        .sdi_i    (sdi_i),
        .cs_n_i   (cs_n_i),
        .lock_i   (nv.busy),
        .sdo_oe_o (sdo_oe_port),
        .fr       (fr)
    );

    dwnv_nv_store #(
        .SAVE_CYCLES (SAVE_CYCLES)
    ) u_store (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .nv    (nv)
    );

    // ************************************************************
    // Pin synchronisers
    // ************************************************************

    logic [2:0] preset_reg;
    logic [1:0] wp_reg;
    logic       preset_low;
    logic       preset_rise;
    logic       protect;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            preset_reg <= 3'h7;
            wp_reg     <= 2'h3;
        end else begin
            preset_reg <= {preset_reg[1:0], reload_strobe_n_i};
            wp_reg     <= {wp_reg[0], write_protect_n_i};
        end
    end

    assign preset_low  = !preset_reg[1];
    assign preset_rise = preset_reg[1] && !preset_reg[2];
    assign protect     = !wp_reg[1];

    // ************************************************************
    // Power-on restore
    // ************************************************************

    // Held for one cycle after release so the restore reads settled slots.
    logic boot_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            boot_reg <= 1'b1;
        else
            boot_reg <= 1'b0;
    end

    // ************************************************************
    // Command selection and repeat
    // ************************************************************

    logic [15:0] rep_word_reg;
    logic        rep_valid_reg;
    logic [15:0] cmd_word;
    logic        exec;
    logic [3:0]  op;
    logic [3:0]  addr;
    logic [7:0]  data;
    logic        ch;
    logic        addr_ok;
    logic        wipe_ok;

    // A bare strobe reuses the stored frame only when the last frame was repeatable; otherwise it does nothing.
    assign cmd_word = fr.frame_ok ? fr.word : rep_word_reg;
    assign exec     = (fr.frame_ok || (fr.bare_strobe && rep_valid_reg)) && !nv.busy;
    assign op       = cmd_word[dwnv_pkg::CMD_LSB +: 4];
    assign addr     = cmd_word[dwnv_pkg::ADDR_LSB +: 4];
    assign data     = cmd_word[dwnv_pkg::DATA_LSB +: 8];
    assign ch       = addr[0];
    assign addr_ok  = (addr[3:1] == 3'h0);
    assign wipe_ok  = exec && !protect && addr_ok;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rep_word_reg  <= 16'h0000;
            rep_valid_reg <= 1'b0;
        end else if (fr.frame_ok && !nv.busy) begin
            rep_word_reg  <= fr.word;
            rep_valid_reg <= dwnv_pkg::dwnv_is_repeatable(
                fr.word[dwnv_pkg::CMD_LSB +: 4]);
        end
    end

    // ************************************************************
    // Wiper scratch registers
    // ************************************************************

    logic [7:0] wiper_scratch_reg [2];
    logic [7:0] wiper_scratch_next [2];
    logic [7:0] slot [2];

    assign slot[0] = nv.slot0;
    assign slot[1] = nv.slot1;

    // Priority: power-on restore, preset held low, preset release, then commands.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            wiper_scratch_next[i] = wiper_scratch_reg[i];
            if (boot_reg) begin
                wiper_scratch_next[i] = slot[i];
            end else if (preset_low) begin
                wiper_scratch_next[i] = dwnv_pkg::WIPER_MID;
            end else if (preset_rise) begin
                wiper_scratch_next[i] = slot[i];
            end else if (exec && op == dwnv_pkg::CMD_RELOAD_ALL) begin
                wiper_scratch_next[i] = slot[i];
            end else if (exec && addr_ok && ch == 1'(i)) begin
                case (op)
                    dwnv_pkg::CMD_RELOAD: begin
                        wiper_scratch_next[i] = slot[i];
                    end
                    dwnv_pkg::CMD_LOAD: begin
                        if (wipe_ok)
                            wiper_scratch_next[i] = data;
                    end
                    dwnv_pkg::CMD_INC_STEP,
                    dwnv_pkg::CMD_DEC_STEP,
                    dwnv_pkg::CMD_INC_6DB,
                    dwnv_pkg::CMD_DEC_6DB: begin
                        if (wipe_ok)
                            wiper_scratch_next[i] =
                                dwnv_pkg::dwnv_step(wiper_scratch_reg[i], op);
                    end
                    default: begin
                        wiper_scratch_next[i] = wiper_scratch_reg[i];
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wiper_scratch_reg[0] <= dwnv_pkg::WIPER_MID;
            wiper_scratch_reg[1] <= dwnv_pkg::WIPER_MID;
        end else begin
            wiper_scratch_reg[0] <= wiper_scratch_next[0];
            wiper_scratch_reg[1] <= wiper_scratch_next[1];
        end
    end

    // The analog switch network decodes these codes: zero at B, all ones at A.
    assign wiper1_o = wiper_scratch_reg[0];
    assign wiper2_o = wiper_scratch_reg[1];

    // ************************************************************
    // Save requests
    // ************************************************************

    // Saves are also refused under write protect so the stored settings stay intact.
    logic save_go;

    assign save_go = exec && op == dwnv_pkg::CMD_SAVE && addr_ok && !protect;

    always_comb begin
        nv.save_req  = save_go;
        nv.save_ch   = ch;
        nv.save_data = wiper_scratch_reg[ch];
    end

    // ************************************************************
    // Ready flag
    // ************************************************************

    logic ready_reg;
    logic ready_set;
    logic ready_clr;

    assign ready_set = nv.done || preset_rise ||
                       (exec && (op == dwnv_pkg::CMD_RELOAD || op == dwnv_pkg::CMD_RELOAD_ALL));
    assign ready_clr = save_go || preset_low;

    // A completion in the same cycle as a new clear still shows as ready.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            ready_reg <= dwnv_pkg::READY_RESET;
        else if (ready_set)
            ready_reg <= 1'b1;
        else if (ready_clr)
            ready_reg <= 1'b0;
    end

    // ************************************************************
    // Open-drain pins
    // ************************************************************

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sdo_o      <= 1'b0;
            sdo_oe_o   <= 1'b0;
            ready_o    <= 1'b0;
            ready_oe_o <= 1'b0;
        end else begin
            sdo_o      <= 1'b0;
            sdo_oe_o   <= sdo_oe_port;
            ready_o    <= 1'b0;
            ready_oe_o <= !ready_reg;
        end
    end

endmodule
`default_nettype wire

// ### verif/dwnv_ctrl_monitor.sv
// Port checker of the dual wiper control block, bound into every instance.
`timescale 1ns/1ps
`default_nettype none
module dwnv_ctrl_monitor #(
    parameter int SAVE_CYCLES = dwnv_pkg::SAVE_CYCLES
) (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       sclk_i,
    input wire logic       sdi_i,
    input wire logic       cs_n_i,
    input wire logic       sdo_o,
    input wire logic       sdo_oe_o,
    input wire logic       reload_strobe_n_i,
    input wire logic       write_protect_n_i,
    input wire logic       ready_o,
    input wire logic       ready_oe_o,
    input wire logic [7:0] wiper1_o,
    input wire logic [7:0] wiper2_o
);
    // ****************************************
    // Helper counters
    // ****************************************
    // Cycles since the last chip-select rise or preset edge; wipers may only move soon after.
    logic [3:0]  quiet_reg;
    logic [31:0] busy_reg;
    logic        pre_reg;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            quiet_reg <= 4'h0;
        end else if ($rose(cs_n_i) || $changed(reload_strobe_n_i)) begin
            quiet_reg <= 4'h0;
        end else if (quiet_reg != 4'hf) begin
            quiet_reg <= quiet_reg + 4'h1;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_reg <= 32'h0;
        end else begin
            busy_reg <= ready_oe_o ? busy_reg + 32'h1 : 32'h0;
        end
    end
    // A busy spell that saw the preset pin low is not a timed save.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_reg <= 1'b0;
        end else if (!ready_oe_o) begin
            pre_reg <= 1'b0;
        end else if (!reload_strobe_n_i) begin
            pre_reg <= 1'b1;
        end
    end
    // ****************************************
    // Assertions
    // ****************************************
    default clocking mon_cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    drain_zero_a: assert property (!sdo_o && !ready_o)
        else $error("open drain output drives high");
    sdo_idle_a: assert property (cs_n_i [*5] |-> !sdo_oe_o)
        else $error("serial output pulled while deselected");
    wiper_quiet_a: assert property (($changed(wiper1_o) || $changed(wiper2_o))
        |-> quiet_reg < 4'h8)
        else $error("wiper moved without a frame end");
    save_lock_a: assert property (ready_oe_o && $past(ready_oe_o, 6)
        && reload_strobe_n_i && $past(reload_strobe_n_i, 6)
        |-> $stable(wiper1_o) && $stable(wiper2_o))
        else $error("wiper moved during a save");
    save_min_a: assert property ($fell(ready_oe_o) && !pre_reg && busy_reg > 32'h4
        |-> busy_reg >= SAVE_CYCLES)
        else $error("save ended too early");
    save_max_a: assert property (!pre_reg |-> busy_reg <= SAVE_CYCLES + 6)
        else $error("save lasted too long");
    preset_mid_a: assert property (!reload_strobe_n_i [*5]
        |-> wiper1_o == dwnv_pkg::WIPER_MID && wiper2_o == dwnv_pkg::WIPER_MID)
        else $error("preset low did not force midscale");
    preset_busy_a: assert property (!reload_strobe_n_i [*5] |-> ready_oe_o)
        else $error("ready shown while preset held");
    cover property ($fell(ready_oe_o) && busy_reg >= SAVE_CYCLES);
    cover property (!reload_strobe_n_i [*5]);
    cover property ($changed(wiper1_o) && quiet_reg < 4'h8);
endmodule
bind dwnv_ctrl dwnv_ctrl_monitor #(.SAVE_CYCLES(SAVE_CYCLES)) i_dwnv_ctrl_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk_i), .sdi_i(sdi_i), .cs_n_i(cs_n_i),
    .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .reload_strobe_n_i(reload_strobe_n_i),
    .write_protect_n_i(write_protect_n_i), .ready_o(ready_o), .ready_oe_o(ready_oe_o),
    .wiper1_o(wiper1_o), .wiper2_o(wiper2_o));
`default_nettype wire

// ### verif/dwnv_host_model.sv
// Host serial master that sends frames and collects the chained word from the output line.
`timescale 1ns/1ps
`default_nettype none
module dwnv_host_model (
    input  wire logic clk_i,
    input  wire logic sdo_line_i,
    output var logic  sclk_o,
    output var logic  sdi_o,
    output var logic  cs_n_o
);
    logic [31:0] rx_word;
    initial begin
        sclk_o  = 1'b0;
        sdi_o   = 1'b1;
        cs_n_o  = 1'b1;
        rx_word = 32'h0;
    end
    task automatic start_frame();
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    // Data is set up while the clock is low; each phase spans three system cycles.
    task automatic put_bit(input logic b);
        sdi_o <= b;
        repeat (3) @(posedge clk_i);
        sclk_o  <= 1'b1;
        rx_word <= {rx_word[30:0], sdo_line_i};
        repeat (3) @(posedge clk_i);
        sclk_o  <= 1'b0;
    endtask
    // The serial clock stands still and the data line leaves its last level once released.
    task automatic end_frame();
        repeat (3) @(posedge clk_i);
        cs_n_o <= 1'b1;
        sdi_o  <= !sdi_o;
        repeat (10) @(posedge clk_i);
    endtask
    task automatic frame16(input logic [15:0] w);
        start_frame();
        for (int i = 15; i >= 0; i--) put_bit(w[i]);
        end_frame();
    endtask
    task automatic frame32(input logic [31:0] w);
        start_frame();
        for (int i = 31; i >= 0; i--) put_bit(w[i]);
        end_frame();
    endtask
    task automatic strobe();
        start_frame();
        end_frame();
    endtask
    task automatic nop_release(output logic wp_n);
        frame16(16'h0000);
        wp_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench of the dual wiper control block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int SAVE_CYC = 400;
    logic       clk_i;
    logic       rst_i;
    logic       reload_strobe_n_i;
    logic       write_protect_n_i;
    logic       sclk;
    logic       sdi;
    logic       cs_n;
    logic       sdo_o;
    logic       sdo_oe_o;
    logic       ready_o;
    logic       ready_oe_o;
    logic       wp_n;
    logic [7:0] wiper1_o;
    logic [7:0] wiper2_o;
    wire logic  sdo_line = !sdo_oe_o;
    int         failures = 0;
    int         checks_done = 0;
    localparam logic [15:0] STEP_W[16] = '{16'hb010, 16'he000, 16'hffff, 16'h6000,
        16'hffff, 16'hc000, 16'hffff, 16'h4000, 16'hffff, 16'h0000, 16'hffff,
        16'hb0ff, 16'he000, 16'hc000, 16'hb000, 16'h6000};
    localparam logic [7:0] STEP_E[16] = '{8'h10, 8'h11, 8'h12, 8'h11, 8'h10, 8'h20,
        8'h40, 8'h20, 8'h10, 8'h10, 8'h10, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00};
    dwnv_ctrl #(.SAVE_CYCLES(SAVE_CYC)) i_dwnv_ctrl (.clk_i(clk_i), .rst_i(rst_i),
        .sclk_i(sclk), .sdi_i(sdi), .cs_n_i(cs_n), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
        .reload_strobe_n_i(reload_strobe_n_i), .write_protect_n_i(write_protect_n_i),
        .ready_o(ready_o), .ready_oe_o(ready_oe_o), .wiper1_o(wiper1_o), .wiper2_o(wiper2_o));
    dwnv_host_model i_host (.clk_i(clk_i), .sdo_line_i(sdo_line), .sclk_o(sclk),
        .sdi_o(sdi), .cs_n_o(cs_n));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic send(input logic [15:0] w);
        i_host.frame16(w);
    endtask
    // Bounded wait for the ready line; a hung save shows as a ready mismatch.
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready_oe_o !== 1'b0 && n < SAVE_CYC + 50) begin
            @(posedge clk_i);
            n++;
        end
        chk("ready", 16'h1, {15'h0, !ready_oe_o});
    endtask
    task automatic t_load();
        send(16'hb040);
        chk("wipers", 16'h4080, {wiper1_o, wiper2_o});
        send(16'hb180);
        chk("readback", 16'hb040, i_host.rx_word[15:0]);
        send(16'hb0ff);
        send(16'hb100);
        chk("wipers", 16'hff00, {wiper1_o, wiper2_o});
        chk("readback", 16'hb0ff, i_host.rx_word[15:0]);
        send(16'hb333);
        chk("wipers", 16'hff00, {wiper1_o, wiper2_o});
        i_host.frame32(32'hb011_b122);
        chk("wipers", 16'hff22, {wiper1_o, wiper2_o});
        $display("test load done");
    endtask
    task automatic t_save();
        send(16'hb040);
        send(16'hb155);
        send(16'h20aa);
        chk("ready", 16'h0, {15'h0, !ready_oe_o});
        send(16'hb0ff);
        i_host.strobe();
        wait_ready();
        chk("wipers", 16'h4055, {wiper1_o, wiper2_o});
        send(16'h2100);
        wait_ready();
        send(16'hb033);
        send(16'hb100);
        send(16'h1000);
        send(16'h1100);
        chk("wipers", 16'h4055, {wiper1_o, wiper2_o});
        $display("test save done");
    endtask
    task automatic t_step();
        for (int i = 0; i < 16; i++) begin
            if (STEP_W[i] == 16'hffff)
                i_host.strobe();
            else
                send(STEP_W[i]);
            chk("step", {8'h0, STEP_E[i]}, {8'h0, wiper1_o});
        end
        $display("test step done");
    endtask
    task automatic t_preset();
        send(16'hb0aa);
        reload_strobe_n_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk("wipers", 16'h8080, {wiper1_o, wiper2_o});
        chk("ready", 16'h0, {15'h0, !ready_oe_o});
        reload_strobe_n_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk("wipers", 16'h4055, {wiper1_o, wiper2_o});
        chk("ready", 16'h1, {15'h0, !ready_oe_o});
        $display("test preset done");
    endtask
    task automatic t_protect();
        send(16'hb0ee);
        send(16'hb1ee);
        write_protect_n_i <= 1'b0;
        send(16'hb011);
        send(16'he100);
        send(16'h2000);
        chk("ready", 16'h1, {15'h0, !ready_oe_o});
        chk("wipers", 16'heeee, {wiper1_o, wiper2_o});
        send(16'h1000);
        chk("wipers", 16'h40ee, {wiper1_o, wiper2_o});
        send(16'h8000);
        wait_ready();
        chk("wipers", 16'h4055, {wiper1_o, wiper2_o});
        i_host.nop_release(wp_n);
        write_protect_n_i <= wp_n;
        $display("test protect done");
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #5_000_000;
        failures++;
        stop_test();
    end
    initial begin
        rst_i = 1'b1;
        reload_strobe_n_i = 1'b1;
        write_protect_n_i = 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("wipers", 16'h8080, {wiper1_o, wiper2_o});
        chk("ready", 16'h1, {15'h0, !ready_oe_o});
        t_load();
        t_save();
        t_step();
        t_preset();
        t_protect();
        stop_test();
    end
endmodule
`default_nettype wire
